/* lpvg_pkg.sv */
// Functional notes
// - each line starts with mode, colour control bytes
// - read downward from top of 8K/32K block
// - every line decoded on its own
// - graphics line lasts two scans per count step
// - character row height is count plus one scans
// - mode bits 7:6 pick one of four display modes
// - colour byte: bits 3:0 colour, 5:4 register select
// - write only if bit 7 set; bit 6 clear gives unit colour
// - four-colour modes show colour registers only
// - 4-bit code is system colour, 2-bit picks register
// - field of 8 blobs from one byte pair
// - consume mode-dependent data bytes, then next line
// - characters are 8 blobs wide from character ROM
// - four-colour index: upper and lower bit, msb first
// - sixteen-colour: low byte bg/fg, high-byte bit (graphics) or dot bit (character) chooses
`default_nettype none
package lpvg_pkg;

  localparam int unsigned AXI_AW = 8;
  localparam int unsigned MEM_AW = 16;

  localparam logic [15:0] TOP_8K  = 16'h1fff;
  localparam logic [15:0] TOP_32K = 16'h7fff;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_COLOUR = 8'h08;

  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_BIG_BIT = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;

  localparam int unsigned ST_MODE_LSB  = 8;
  localparam int unsigned ST_SCAN_LSB  = 16;

  localparam int unsigned MB_MODE_LSB = 6;
  localparam int unsigned MB_DEF_LSB  = 4;
  localparam int unsigned MB_REP_LSB  = 0;

  localparam int unsigned CC_WE_BIT    = 7;
  localparam int unsigned CC_MULTI_BIT = 6;
  localparam int unsigned CC_SEL_LSB   = 4;
  localparam int unsigned CC_COL_LSB   = 0;

  localparam logic [3:0] COLOUR_BLACK = 4'h0;
  localparam logic [3:0] COLOUR_WHITE = 4'hf;

  localparam logic [2:0] FIELD_LAST_BLOB = 3'h7;
  localparam logic [7:0] IDX_MODE  = 8'h00;
  localparam logic [7:0] IDX_COL   = 8'h01;
  localparam logic [7:0] IDX_DATA0 = 8'h02;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    MODE_G4  = 2'b00,
    MODE_C4  = 2'b01,
    MODE_G16 = 2'b10,
    MODE_C16 = 2'b11
  } lpvg_mode_t;

  // data bytes per line: two per field, 11, 22, 44 or 66 fields by def
  function automatic logic [7:0] data_bytes(input logic [1:0] def);
    case (def)
      2'b00:   data_bytes = 8'h16;
      2'b01:   data_bytes = 8'h2c;
      2'b10:   data_bytes = 8'h58;
      default: data_bytes = 8'h84;
    endcase
  endfunction

  function automatic logic [5:0] line_scans(input logic [1:0] mode, input logic [3:0] rep);
    if (mode[0]) begin
      line_scans = {2'h0, rep} + 6'h01;
    end else begin
      line_scans = {1'b0, rep, 1'b0} + 6'h02;
    end
  endfunction

endpackage
`default_nettype wire

/* lpvg_blob.sv */
`timescale 1ns/1ps
`default_nettype none
module lpvg_blob (
  // line and field
  input  wire logic [1:0]  mode,
  input  wire logic        unit,
  input  wire logic [7:0]  hi_byte,
  input  wire logic [7:0]  lo_byte,
  input  wire logic [7:0]  dots,
  input  wire logic [2:0]  blob,
  // colour registers, entry 0 in the low nibble
  input  wire logic [15:0] colours,
  // result
  output logic      [3:0]  colour
);

  function automatic logic [3:0] pick(input logic [15:0] regs, input logic [1:0] idx);
    pick = regs[{idx, 2'b00} +: 4];
  endfunction

  logic [2:0] sel;

  always_comb begin
    sel = lpvg_pkg::FIELD_LAST_BLOB - blob; // msb first
    if (unit) begin
      colour = pick(colours, 2'h0);
    end else begin
      case (mode)
        lpvg_pkg::MODE_G4:  colour = pick(colours, {hi_byte[sel], lo_byte[sel]});
        lpvg_pkg::MODE_C4:  colour = pick(colours, {lo_byte[sel], dots[sel]});
        lpvg_pkg::MODE_G16: colour = hi_byte[sel] ? lo_byte[7:4] : lo_byte[3:0];
        default:            colour = dots[sel] ? lo_byte[7:4] : lo_byte[3:0];
      endcase
    end
  end

endmodule // lpvg_blob
`default_nettype wire

/* lpvg_top.sv */
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lpvg_top #(
  parameter int unsigned FRAME_SCANS  = 520,
  parameter int unsigned HBLANK_TICKS = 8,
  parameter int unsigned PIX_DIV      = 1
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // axi4-lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // display ram read port, data must stand while the strobe is high
  output logic [15:0]      MEM_ADDR,
  output logic             MEM_RD,
  input  wire logic [7:0]  MEM_RDATA,
  // character rom, data valid in the same cycle as the address
  output logic [11:0]      CGEN_ADDR,
  input  wire logic [7:0]  CGEN_DATA,
  // raster
  output logic [3:0]       VIDEO_COLOUR,
  output logic             VIDEO_ACTIVE,
  output logic             SCAN_START,
  output logic             FRAME_START
);

  if (FRAME_SCANS < 2 || FRAME_SCANS > 1023 || HBLANK_TICKS < 1 || HBLANK_TICKS > 255
      || PIX_DIV < 1 || PIX_DIV > 255) begin : g_param_check
    $error("lpvg_top: parameter out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_FETCH_REQ = 3'b001,
    ST_FETCH_CAP = 3'b010,
    ST_LOAD      = 3'b011,
    ST_BLOB      = 3'b100,
    ST_HBLANK    = 3'b101
  } lpvg_state_t;

  localparam logic [9:0] FRAME_LAST = 10'(FRAME_SCANS - 1);
  localparam logic [7:0] HB_LAST    = 8'(HBLANK_TICKS - 1);
  localparam logic [7:0] DIV_LAST   = 8'(PIX_DIV - 1);

  // line buffer, widest line is 132 bytes
  logic [7:0] line_buf [132];

  // software-visible control
  logic [1:0]  ctrl_reg, ctrl_next;

  // fetch and raster state
  lpvg_state_t state_reg, state_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0]  idx_reg, idx_next;
  logic [7:0]  nbytes_reg, nbytes_next;
  logic [7:0]  mode_reg, mode_next;
  logic        unit_reg, unit_next;
  logic [15:0] colours_reg, colours_next;
  logic [5:0]  scan_reg, scan_next;
  logic [9:0]  fscan_reg, fscan_next;
  logic [6:0]  field_reg, field_next;
  logic [2:0]  blob_reg, blob_next;
  logic [7:0]  hb_reg, hb_next;
  logic [7:0]  div_reg, div_next;
  logic [7:0]  hi_reg, hi_next;
  logic [7:0]  lo_reg, lo_next;
  logic [15:0] mem_addr_reg, mem_addr_next;
  logic        mem_rd_reg, mem_rd_next;
  logic [11:0] cgen_reg, cgen_next;
  logic [3:0]  vcol_reg, vcol_next;
  logic        vact_reg, vact_next;
  logic        sstart_reg, sstart_next;
  logic        fstart_reg, fstart_next;

  // axi state
  logic        aw_have_reg, aw_have_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic        w_have_reg, w_have_next;
  logic [31:0] w_data_reg, w_data_next;
  logic        w_strb_reg, w_strb_next;
  logic        awrdy_reg, awrdy_next;
  logic        wrdy_reg, wrdy_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        arrdy_reg, arrdy_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;

  logic        tick;
  logic [3:0]  blob_colour;
  logic [15:0] top_addr;
  logic [6:0]  field_last;

  assign tick       = (div_reg == DIV_LAST);
  assign top_addr   = ctrl_reg[lpvg_pkg::CTRL_BIG_BIT] ? lpvg_pkg::TOP_32K : lpvg_pkg::TOP_8K;
  assign field_last = nbytes_reg[7:1] - 7'h01;

  lpvg_blob u_blob (
    .mode    (mode_reg[lpvg_pkg::MB_MODE_LSB +: 2]),
    .unit    (unit_reg),
    .hi_byte (hi_reg),
    .lo_byte (lo_reg),
    .dots    (CGEN_DATA),
    .blob    (blob_reg),
    .colours (colours_reg),
    .colour  (blob_colour)
  );

  // axi4-lite slave; one write and one read in flight
  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next  = w_have_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    ctrl_next    = ctrl_reg;
    if (S_AXI_AWVALID && awrdy_reg) begin
      aw_have_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && wrdy_reg) begin
      w_have_next = 1'b1;
      w_data_next = S_AXI_WDATA;
      w_strb_next = S_AXI_WSTRB[0];
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = lpvg_pkg::RESP_OKAY;
      if (aw_addr_reg == lpvg_pkg::OFF_CTRL) begin
        if (w_strb_reg) begin
          ctrl_next = w_data_reg[1:0];
        end
      end else if (aw_addr_reg != lpvg_pkg::OFF_STATUS && aw_addr_reg != lpvg_pkg::OFF_COLOUR) begin
        bresp_next = lpvg_pkg::RESP_DECERR;
      end
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (S_AXI_ARVALID && arrdy_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = lpvg_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        lpvg_pkg::OFF_CTRL:   rdata_next = {30'h0, ctrl_reg};
        lpvg_pkg::OFF_STATUS: rdata_next = {6'h0, fscan_reg, mode_reg, 7'h0,
                                            (state_reg != ST_IDLE)};
        lpvg_pkg::OFF_COLOUR: rdata_next = {16'h0, colours_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = lpvg_pkg::RESP_DECERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
    awrdy_next = !aw_have_next && !bvalid_next;
    wrdy_next  = !w_have_next && !bvalid_next;
    arrdy_next = !rvalid_next;
  end

  // line fetch and raster sequencer
  always_comb begin
    state_next    = state_reg;
    addr_next     = addr_reg;
    idx_next      = idx_reg;
    nbytes_next   = nbytes_reg;
    mode_next     = mode_reg;
    unit_next     = unit_reg;
    colours_next  = colours_reg;
    scan_next     = scan_reg;
    fscan_next    = fscan_reg;
    field_next    = field_reg;
    blob_next     = blob_reg;
    hb_next       = hb_reg;
    hi_next       = hi_reg;
    lo_next       = lo_reg;
    cgen_next     = cgen_reg;
    vcol_next     = vcol_reg;
    vact_next     = vact_reg;
    mem_addr_next = mem_addr_reg;
    mem_rd_next   = 1'b0;
    sstart_next   = 1'b0;
    fstart_next   = 1'b0;
    div_next      = tick ? 8'h00 : div_reg + 8'h01;
    case (state_reg)
      ST_IDLE: begin
        vact_next = 1'b0;
        vcol_next = lpvg_pkg::COLOUR_BLACK;
        if (ctrl_reg[lpvg_pkg::CTRL_EN_BIT]) begin
          addr_next   = top_addr;
          fscan_next  = 10'h000;
          idx_next    = lpvg_pkg::IDX_MODE;
          fstart_next = 1'b1;
          state_next  = ST_FETCH_REQ;
        end
      end
      ST_FETCH_REQ: begin
        mem_rd_next   = 1'b1;
        mem_addr_next = addr_reg;
        state_next    = ST_FETCH_CAP;
      end
      ST_FETCH_CAP: begin
        addr_next  = addr_reg - 16'h0001;
        idx_next   = idx_reg + 8'h01;
        state_next = ST_FETCH_REQ;
        if (idx_reg == lpvg_pkg::IDX_MODE) begin
          mode_next   = MEM_RDATA;
          nbytes_next = lpvg_pkg::data_bytes(MEM_RDATA[lpvg_pkg::MB_DEF_LSB +: 2]);
        end else if (idx_reg == lpvg_pkg::IDX_COL) begin
          unit_next = !MEM_RDATA[lpvg_pkg::CC_MULTI_BIT];
          if (MEM_RDATA[lpvg_pkg::CC_WE_BIT]) begin
            colours_next[{MEM_RDATA[lpvg_pkg::CC_SEL_LSB +: 2], 2'b00} +: 4] =
              MEM_RDATA[lpvg_pkg::CC_COL_LSB +: 4];
          end
        end else if (idx_reg == nbytes_reg + 8'h01) begin
          scan_next   = 6'h00;
          field_next  = 7'h00;
          sstart_next = 1'b1;
          state_next  = ST_LOAD;
        end
      end
      ST_LOAD: begin
        vact_next = 1'b0; // dark load slot keeps every field at 8 blobs
        vcol_next = lpvg_pkg::COLOUR_BLACK;
        if (tick) begin
          hi_next    = line_buf[{field_reg, 1'b0}];
          lo_next    = line_buf[{field_reg, 1'b1}];
          cgen_next  = {line_buf[{field_reg, 1'b0}], scan_reg[3:0]};
          blob_next  = 3'h0;
          state_next = ST_BLOB;
        end
      end
      ST_BLOB: begin
        if (tick) begin
          vcol_next = blob_colour;
          vact_next = 1'b1;
          blob_next = blob_reg + 3'h1;
          if (blob_reg == lpvg_pkg::FIELD_LAST_BLOB) begin
            if (field_reg == field_last) begin
              hb_next    = 8'h00;
              state_next = ST_HBLANK;
            end else begin
              field_next = field_reg + 7'h01;
              state_next = ST_LOAD;
            end
          end
        end
      end
      ST_HBLANK: begin
        vact_next = 1'b0;
        vcol_next = lpvg_pkg::COLOUR_BLACK;
        if (tick) begin
          hb_next = hb_reg + 8'h01;
          if (hb_reg == HB_LAST) begin
            fscan_next = fscan_reg + 10'h001;
            scan_next  = scan_reg + 6'h01;
            field_next = 7'h00;
            if (scan_next == lpvg_pkg::line_scans(mode_reg[lpvg_pkg::MB_MODE_LSB +: 2],
                                                  mode_reg[lpvg_pkg::MB_REP_LSB +: 4])) begin
              idx_next   = lpvg_pkg::IDX_MODE;
              state_next = ST_FETCH_REQ;
              if (fscan_reg >= FRAME_LAST) begin
                addr_next   = top_addr;
                fscan_next  = 10'h000;
                fstart_next = 1'b1;
              end
              if (!ctrl_reg[lpvg_pkg::CTRL_EN_BIT]) begin
                fstart_next = 1'b0;
                state_next  = ST_IDLE;
              end
            end else begin
              sstart_next = 1'b1;
              state_next  = ST_LOAD;
            end
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // buffer holds its own array; only the capture state writes it
  always_ff @(posedge CLK) begin
    if (state_reg == ST_FETCH_CAP && idx_reg >= lpvg_pkg::IDX_DATA0) begin
      line_buf[idx_reg - lpvg_pkg::IDX_DATA0] <= MEM_RDATA;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg     <= lpvg_pkg::CTRL_RESET;
      state_reg    <= ST_IDLE;
      addr_reg     <= 16'h0000;
      idx_reg      <= 8'h00;
      nbytes_reg   <= 8'h16;
      mode_reg     <= 8'h00;
      unit_reg     <= 1'b0;
      colours_reg  <= 16'h0000;
      scan_reg     <= 6'h00;
      fscan_reg    <= 10'h000;
      field_reg    <= 7'h00;
      blob_reg     <= 3'h0;
      hb_reg       <= 8'h00;
      div_reg      <= 8'h00;
      hi_reg       <= 8'h00;
      lo_reg       <= 8'h00;
      mem_addr_reg <= 16'h0000;
      mem_rd_reg   <= 1'b0;
      cgen_reg     <= 12'h000;
      vcol_reg     <= lpvg_pkg::COLOUR_BLACK;
      vact_reg     <= 1'b0;
      sstart_reg   <= 1'b0;
      fstart_reg   <= 1'b0;
      aw_have_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_have_reg   <= 1'b0;
      w_data_reg   <= 32'h0;
      w_strb_reg   <= 1'b0;
      awrdy_reg    <= 1'b0;
      wrdy_reg     <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= lpvg_pkg::RESP_OKAY;
      arrdy_reg    <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h0;
      rresp_reg    <= lpvg_pkg::RESP_OKAY;
    end else begin
      ctrl_reg     <= ctrl_next;
      state_reg    <= state_next;
      addr_reg     <= addr_next;
      idx_reg      <= idx_next;
      nbytes_reg   <= nbytes_next;
      mode_reg     <= mode_next;
      unit_reg     <= unit_next;
      colours_reg  <= colours_next;
      scan_reg     <= scan_next;
      fscan_reg    <= fscan_next;
      field_reg    <= field_next;
      blob_reg     <= blob_next;
      hb_reg       <= hb_next;
      div_reg      <= div_next;
      hi_reg       <= hi_next;
      lo_reg       <= lo_next;
      mem_addr_reg <= mem_addr_next;
      mem_rd_reg   <= mem_rd_next;
      cgen_reg     <= cgen_next;
      vcol_reg     <= vcol_next;
      vact_reg     <= vact_next;
      sstart_reg   <= sstart_next;
      fstart_reg   <= fstart_next;
      aw_have_reg  <= aw_have_next;
      aw_addr_reg  <= aw_addr_next;
      w_have_reg   <= w_have_next;
      w_data_reg   <= w_data_next;
      w_strb_reg   <= w_strb_next;
      awrdy_reg    <= awrdy_next;
      wrdy_reg     <= wrdy_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      arrdy_reg    <= arrdy_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
    end
  end

  assign S_AXI_AWREADY = awrdy_reg;
  assign S_AXI_WREADY  = wrdy_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = arrdy_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign MEM_ADDR      = mem_addr_reg;
  assign MEM_RD        = mem_rd_reg;
  assign CGEN_ADDR     = cgen_reg;
  assign VIDEO_COLOUR  = vcol_reg;
  assign VIDEO_ACTIVE  = vact_reg;
  assign SCAN_START    = sstart_reg;
  assign FRAME_START   = fstart_reg;

endmodule // lpvg_top
`default_nettype wire

/* lpvg_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lpvg_mem_model (
  // clock
  input  wire logic        CLK,
  // display ram read port
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic        MEM_RD,
  output logic      [7:0]  MEM_RDATA,
  // character rom
  input  wire logic [11:0] CGEN_ADDR,
  output logic      [7:0]  CGEN_DATA
);
  logic [7:0] mem [0:65535];
  logic [7:0] idle_q;
  initial begin
    idle_q = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  // the port toggles outside the strobe cycle so a late capture sees wrong data
  always @(posedge CLK) idle_q <= ~idle_q;
  // the fetch captures the byte at the edge that closes the strobe cycle
  assign MEM_RDATA = MEM_RD ? mem[MEM_ADDR] : idle_q;
  assign CGEN_DATA = CGEN_ADDR[11:4] ^ {CGEN_ADDR[3:0], CGEN_ADDR[3:0]};
endmodule // lpvg_mem_model
`default_nettype wire

/* lpvg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module lpvg_checker (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // bus handshakes
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  // memory and raster
  input wire logic [15:0] MEM_ADDR,
  input wire logic        MEM_RD,
  input wire logic        VIDEO_ACTIVE,
  input wire logic        SCAN_START,
  input wire logic        FRAME_START
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic [15:0] last_addr_reg;
  logic        fresh_reg;
  // a restart voids the step check; the top address is judged apart
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fresh_reg     <= 1'b1;
      last_addr_reg <= 16'h0000;
    end else begin
      fresh_reg     <= FRAME_START | (fresh_reg & ~MEM_RD);
      last_addr_reg <= MEM_RD ? MEM_ADDR : last_addr_reg;
    end
  end
  top_addr_a: assert property (FRAME_START |=> MEM_RD && (MEM_ADDR == lpvg_pkg::TOP_8K
    || MEM_ADDR == lpvg_pkg::TOP_32K)) else $error("restart not at top address");
  desc_addr_a: assert property (MEM_RD && !fresh_reg
    |-> MEM_ADDR == last_addr_reg - 16'h0001) else $error("read address not one below previous");
  rd_spacing_a: assert property (MEM_RD |=> !MEM_RD) else $error("reads too close");
  field_run_a: assert property ($rose(VIDEO_ACTIVE) |-> VIDEO_ACTIVE[*8]
    ##1 !VIDEO_ACTIVE) else $error("field is not eight blobs");
  frame_dark_a: assert property (FRAME_START |-> !VIDEO_ACTIVE)
    else $error("active at restart");
  scan_pulse_a: assert property (SCAN_START |=> !SCAN_START) else $error("scan start too long");
  aw_take_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("awready stays after take");
  b_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> ##1 S_AXI_BVALID) else $error("no write response");
  r_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("no read response");
  frame_c: cover property (FRAME_START);
  field_c: cover property ($rose(VIDEO_ACTIVE));
  decerr_c: cover property (S_AXI_BVALID && S_AXI_BRESP == lpvg_pkg::RESP_DECERR);
endmodule // lpvg_checker
bind lpvg_top lpvg_checker chk_i (.CLK(CLK), .RESET_N(RESET_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .VIDEO_ACTIVE(VIDEO_ACTIVE),
  .SCAN_START(SCAN_START), .FRAME_START(FRAME_START));
`default_nettype wire

/* lpvg_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module lpvg_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  resp;
  wire logic   awready, wready, bvalid, arready, rvalid, mem_rd, active, scan_st, frame_st;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] mem_addr;
  wire logic [7:0]  mem_rdata, cgen_data;
  wire logic [11:0] cgen_addr;
  wire logic [3:0]  colour;
  int          n_fail = 0, checked = 0, frames = 0, n_rd = 0, n_scan = 0, cur_line = 2;
  int          exp_reads, exp_scans;
  logic [15:0] top, lstart [0:1];
  logic [32:0] pat [0:2];
  logic [2:0]  blob = 3'h0;
  logic        first_rd = 1'b0;

  always #50 clk = ~clk;

  // short frame and blanking keep the run brief
  lpvg_top #(.FRAME_SCANS(6), .HBLANK_TICKS(1), .PIX_DIV(1)) dut (
    .CLK(clk), .RESET_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata),
    .CGEN_ADDR(cgen_addr), .CGEN_DATA(cgen_data),
    .VIDEO_COLOUR(colour), .VIDEO_ACTIVE(active), .SCAN_START(scan_st), .FRAME_START(frame_st));

  lpvg_mem_model mem_i (.CLK(clk), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata),
    .CGEN_ADDR(cgen_addr), .CGEN_DATA(cgen_data));

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t response got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // mode byte at a, colour byte below it, then hi/lo pairs descending
  task automatic put_line(input logic [15:0] a, input logic [7:0] mb, cb, hi, lo, input int n);
    mem_i.mem[a] = mb;
    mem_i.mem[a - 16'h0001] = cb;
    for (int i = 0; i < n; i += 2) begin
      mem_i.mem[a - 16'h0002 - 16'(i)] = hi;
      mem_i.mem[a - 16'h0003 - 16'(i)] = lo;
    end
  endtask

  // raster and fetch monitor, sampled on the clock edge
  always @(posedge clk) begin
    if (mem_rd) begin
      n_rd++;
      if (first_rd) chk_val({16'h0, mem_addr}, {16'h0, top}, "first address");
      first_rd = 1'b0;
      for (int i = 0; i < 2; i++) if (mem_addr === lstart[i]) cur_line = i;
    end
    if (scan_st) n_scan++;
    if (active) begin
      if (pat[cur_line][32]) chk_val({28'h0, colour},
        {28'h0, pat[cur_line][4*(7-int'(blob))+:4]}, "blob colour");
      blob = blob + 3'h1;
    end else blob = 3'h0;
    if (frame_st) begin
      if (frames > 0) chk_val(32'(n_rd), 32'(exp_reads), "bytes per frame");
      if (frames > 0) chk_val(32'(n_scan), 32'(exp_scans), "scans per frame");
      frames++;
      n_rd = 0;
      n_scan = 0;
      first_rd = 1'b1;
    end
  end

  initial begin
    pat[2] = 33'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(lpvg_pkg::OFF_CTRL);
    chk_val(rd, 32'h0, "ctrl reset");
    axi_rd(lpvg_pkg::OFF_COLOUR);
    chk_val(rd, 32'h0, "colour reset");
    axi_rd(8'h0c);
    chk_resp(resp, lpvg_pkg::RESP_DECERR);
    chk_val(rd, 32'h0, "unmapped read");
    axi_wr(8'h0c, 32'h3);
    chk_resp(resp, lpvg_pkg::RESP_DECERR);
    // 8K block: four-colour low def, then sixteen-colour medium def
    top = lpvg_pkg::TOP_8K;
    lstart[0] = 16'h1fff;
    lstart[1] = 16'h1fe7;
    put_line(16'h1fff, 8'h00, 8'hd5, 8'h00, 8'haa, 22);
    put_line(16'h1fe7, 8'h91, 8'h4a, 8'ha5, 8'h9c, 44);
    pat[0] = {1'b1, 32'h50505050};
    pat[1] = {1'b1, 32'h9c9cc9c9};
    exp_reads = 70;
    exp_scans = 6;
    axi_wr(lpvg_pkg::OFF_CTRL, 32'h1);
    chk_resp(resp, lpvg_pkg::RESP_OKAY);
    while (frames < 3) @(posedge clk);
    axi_rd(lpvg_pkg::OFF_COLOUR);
    chk_val(rd, 32'h0050, "colour regs");
    axi_rd(lpvg_pkg::OFF_STATUS);
    chk_val(rd & 32'h1, 32'h1, "running");
    axi_wr(lpvg_pkg::OFF_CTRL, 32'h0);
    do axi_rd(lpvg_pkg::OFF_STATUS); while (rd[0] !== 1'b0);
    // 32K block: character lines, last one in unit colour
    top = lpvg_pkg::TOP_32K;
    lstart[0] = 16'h7fff;
    lstart[1] = 16'h7f79;
    put_line(16'h7fff, 8'h72, 8'he7, 8'h41, 8'h0f, 132);
    put_line(16'h7f79, 8'he2, 8'h8f, 8'h55, 8'h12, 88);
    pat[0] = 33'h0;
    pat[1] = {1'b1, 32'hffffffff};
    cur_line = 2;
    frames = 0;
    exp_reads = 224;
    exp_scans = 6;
    axi_wr(lpvg_pkg::OFF_CTRL, 32'h3);
    while (frames < 3) @(posedge clk);
    axi_rd(lpvg_pkg::OFF_COLOUR);
    chk_val(rd, 32'h075f, "colour regs");
    summarize;
  end

  // watchdog: both configurations take well under half this span
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    summarize;
  end
endmodule // lpvg_tb
`default_nettype wire
